// ==== core/asr_pkg.sv ====
package asr_pkg;
    // ==========================================================
    // Register numbers
    localparam logic [4:0] ASR_HIGH_WORD = 5'h00;
    localparam logic [4:0] ASR_FLAGS = 5'h02;
    localparam logic [4:0] ASR_SPACE_ID = 5'h03;
    localparam logic [4:0] ASR_CYCLES = 5'h04;
    // ==========================================================
    // Field positions
    localparam int CCR_WIDE_LSB = 4;
    localparam int CCR_NARROW_LSB = 0;
    localparam int FLAG_N = 3;
    localparam int FLAG_Z = 2;
    localparam int FLAG_V = 1;
    localparam int FLAG_C = 0;
    localparam int HIGH_WORD_W = 32;
    localparam int CNT_BITS = 63;
    localparam int NPT_BIT = 63;
    // ==========================================================
    // Reset values
    localparam logic NPT_RESET = 1'b1;
    localparam logic [62:0] CNT_RESET = 63'h0;
    localparam logic [31:0] HIGH_WORD_RESET = 32'h0;
    localparam logic [7:0] CCR_RESET = 8'h00;
    localparam logic [7:0] SPACE_ID_RESET = 8'h00;
    // ==========================================================
    // Space identifier ranges
    localparam logic [7:0] ASI_RESTRICT_TOP = 8'h7F;
    localparam logic [7:0] ASI_PRIV_LOW = 8'h30;
    // ==========================================================
    // Counter lifetime
    localparam longint CLK_HZ = 200_000_000;
    localparam longint LIFE_YEARS = 10;
    localparam longint LIFE_CYCLES = LIFE_YEARS * 64'd31_536_000 * CLK_HZ;
    localparam int CNT_MIN_BITS = $clog2(LIFE_CYCLES + 64'd1);
    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        MODE_USER = 2'b00,
        MODE_PRIV = 2'b01,
        MODE_HYPER = 2'b10
    } asr_mode_t;
    typedef enum logic [2:0] {
        OP_NONE = 3'b000,
        OP_RD_ASR = 3'b001,
        OP_WR_ASR = 3'b010,
        OP_RD_PR = 3'b011,
        OP_WR_PR = 3'b100
    } asr_op_t;
    typedef enum logic [1:0] {
        ALU_ADD = 2'b00,
        ALU_SUB = 2'b01,
        ALU_LOGIC = 2'b10
    } asr_alu_t;
    typedef struct packed {
        asr_op_t op;
        logic [4:0] addr;
        logic [63:0] wdata;
    } asr_sr_req_t;
    typedef struct packed {
        logic valid;
        asr_alu_t kind;
        logic [63:0] a;
        logic [63:0] b;
        logic [63:0] res;
    } asr_alu_req_t;
    typedef struct packed {
        logic valid;
        logic [63:0] product;
    } asr_mul_req_t;
    typedef struct packed {
        logic valid;
        logic [7:0] ccr;
    } asr_trap_ret_t;
    typedef struct packed {
        logic valid;
        logic imm_form;
        logic [7:0] alternate_space_id;
    } asr_alt_req_t;
    typedef struct packed {
        logic valid;
        logic [63:0] data;
        logic illegal;
        logic priv_opcode;
        logic priv_action;
    } asr_resp_t;
    typedef struct packed {
        logic valid;
        logic [7:0] alternate_space_id;
        logic priv_action;
    } asr_alt_resp_t;
    typedef struct packed {
        logic [31:0] y;
        logic [7:0] ccr;
        logic [7:0] alternate_space_id;
        logic npt;
        logic [62:0] cnt;
        asr_resp_t resp;
        asr_alt_resp_t alt;
    } asr_state_t;
endpackage

// ==== core/asr_regs.sv ====
`timescale 1ns/1ps
// Overview of operation
// - Multiplies load product upper word into register
// - Divides take dividend upper word from it
// - High-word register upper half reads zero
// - Flag updates set wide and narrow groups
// - Negative flag follows sign at group width
// - Zero flag set when group result zero
// - Overflow flag marks unrepresentable group result
// - Add carry from bit 63 or 31
// - Subtract carry is unsigned less-than
// - Flags change only on ALU, write, return
// - Wide group sits in bits 7:4
// - Narrow group sits in bits 3:0
// - Space id writable always, used by imm
// - Restricted space ids raise privileged action in user mode, only 30-7F in privileged
// - Counter field advances every strand cycle
// - Bit 63 is nonprivileged read block
// - Hyper reads/writes counter, privileged write illegal
// - User counter read blocked when bit set
// - User privileged read/write raises opcode fault
// - Power-on sets block bit, clears counter
// - Read after write returns written plus some
// - Narrow counter lasts ten years, zero-filled
module asr_regs
    import asr_pkg::*;
#(
    parameter int CNT_W = CNT_BITS
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    // Pipeline requests
    input wire asr_mode_t i_mode,
    input wire asr_sr_req_t i_sr,
    input wire asr_alu_req_t i_alu,
    input wire asr_mul_req_t i_mul,
    input wire asr_trap_ret_t i_trap_ret,
    input wire asr_alt_req_t i_alt,
    // Answers
    output asr_resp_t o_resp,
    output asr_alt_resp_t o_alt,
    output logic [31:0] o_div_hi,
    output logic [7:0] o_ccr
);
    // ==========================================================
    // Parameter check
    // Narrower counters save area but must survive ten years
    if (CNT_W < CNT_MIN_BITS || CNT_W > CNT_BITS) begin : g_bad_width
        $error("CNT_W out of range");
    end

    localparam logic [62:0] CNT_MASK = {63{1'b1}} >> (CNT_BITS - CNT_W);

    // ==========================================================
    // Flag computation
    function automatic logic [7:0] calc_flags(input asr_alu_req_t r);
        logic [64:0] s65;
        logic [32:0] s33;
        logic [63:0] res;
        logic xc;
        logic ic;
        logic xv;
        logic iv;
        logic [3:0] wide;
        logic [3:0] narrow;
        s65 = {1'b0, r.a} + {1'b0, r.b};
        s33 = {1'b0, r.a[31:0]} + {1'b0, r.b[31:0]};
        res = r.res;
        xc = 1'b0;
        ic = 1'b0;
        xv = 1'b0;
        iv = 1'b0;
        case (r.kind)
            ALU_ADD: begin
                res = s65[63:0];
                xc = s65[64];
                ic = s33[32];
                xv = (r.a[63] == r.b[63]) && (res[63] != r.a[63]);
                iv = (r.a[31] == r.b[31]) && (res[31] != r.a[31]);
            end
            ALU_SUB: begin
                res = r.a - r.b;
                xc = r.a < r.b;
                ic = r.a[31:0] < r.b[31:0];
                xv = (r.a[63] != r.b[63]) && (res[63] != r.a[63]);
                iv = (r.a[31] != r.b[31]) && (res[31] != r.a[31]);
            end
            default: begin
                res = r.res;
            end
        endcase
        wide[FLAG_N] = res[63];
        wide[FLAG_Z] = (res == 64'h0);
        wide[FLAG_V] = xv;
        wide[FLAG_C] = xc;
        narrow[FLAG_N] = res[31];
        narrow[FLAG_Z] = (res[31:0] == 32'h0);
        narrow[FLAG_V] = iv;
        narrow[FLAG_C] = ic;
        calc_flags = 8'h00;
        calc_flags[CCR_WIDE_LSB +: 4] = wide;
        calc_flags[CCR_NARROW_LSB +: 4] = narrow;
    endfunction

    // ==========================================================
    // State
    asr_state_t st_r;
    asr_state_t st_nxt;

    logic rd_any;
    logic wr_any;
    logic [63:0] rd_data;
    logic exc_ill;
    logic exc_popc;
    logic exc_pact;
    logic wr_ok;
    logic [7:0] alt_id;
    logic alt_pa;

    // ==========================================================
    // State register access decode
    always_comb begin
        rd_any = (i_sr.op == OP_RD_ASR) || (i_sr.op == OP_RD_PR);
        wr_any = (i_sr.op == OP_WR_ASR) || (i_sr.op == OP_WR_PR);
        rd_data = 64'h0;
        exc_ill = 1'b0;
        exc_popc = 1'b0;
        exc_pact = 1'b0;
        case (i_sr.op)
            OP_RD_ASR, OP_WR_ASR: begin
                case (i_sr.addr)
                    ASR_HIGH_WORD: rd_data = {32'h0, st_r.y};
                    ASR_FLAGS: rd_data = {56'h0, st_r.ccr};
                    ASR_SPACE_ID: rd_data = {56'h0, st_r.alternate_space_id};
                    ASR_CYCLES: begin
                        // No dedicated counter write exists
                        if (i_sr.op == OP_WR_ASR) begin
                            exc_ill = 1'b1;
                        end else if (i_mode == MODE_USER && st_r.npt) begin
                            exc_pact = 1'b1;
                        end else begin
                            rd_data = {st_r.npt, st_r.cnt & CNT_MASK};
                        end
                    end
                    default: exc_ill = 1'b1;
                endcase
            end
            OP_RD_PR, OP_WR_PR: begin
                if (i_mode == MODE_USER) begin
                    exc_popc = 1'b1;
                end else if (i_sr.addr != ASR_CYCLES) begin
                    exc_ill = 1'b1;
                end else if (i_sr.op == OP_WR_PR && i_mode != MODE_HYPER) begin
                    exc_ill = 1'b1;
                end else begin
                    rd_data = {st_r.npt, st_r.cnt & CNT_MASK};
                end
            end
            default: rd_data = 64'h0;
        endcase
        wr_ok = wr_any && !exc_ill && !exc_popc && !exc_pact;
    end

    // ==========================================================
    // Alternate space check
    always_comb begin
        alt_id = i_alt.imm_form ? st_r.alternate_space_id : i_alt.alternate_space_id;
        alt_pa = 1'b0;
        if (i_mode == MODE_USER && alt_id <= ASI_RESTRICT_TOP) begin
            alt_pa = 1'b1;
        end
        if (i_mode == MODE_PRIV && alt_id >= ASI_PRIV_LOW &&
            alt_id <= ASI_RESTRICT_TOP) begin
            alt_pa = 1'b1;
        end
    end

    // ==========================================================
    // Next state
    always_comb begin
        st_nxt = st_r;
        // Counter runs every cycle; a write overrides it
        st_nxt.cnt = (st_r.cnt + 63'h1) & CNT_MASK;
        st_nxt.resp.valid = rd_any || wr_any;
        st_nxt.resp.data = rd_any ? rd_data : 64'h0;
        st_nxt.resp.illegal = exc_ill;
        st_nxt.resp.priv_opcode = exc_popc;
        st_nxt.resp.priv_action = exc_pact;
        if (wr_ok) begin
            case (i_sr.addr)
                ASR_HIGH_WORD: st_nxt.y = i_sr.wdata[31:0];
                ASR_FLAGS: st_nxt.ccr = i_sr.wdata[7:0];
                ASR_SPACE_ID: st_nxt.alternate_space_id = i_sr.wdata[7:0];
                ASR_CYCLES: begin
                    st_nxt.npt = i_sr.wdata[NPT_BIT];
                    st_nxt.cnt = i_sr.wdata[62:0] & CNT_MASK;
                end
                default: st_nxt.y = st_r.y;
            endcase
        end
        // Product upper word wins over an explicit write
        if (i_mul.valid) begin
            st_nxt.y = i_mul.product[63:HIGH_WORD_W];
        end
        // Flags: ALU, then explicit write, then trap return
        if (i_alu.valid && !(wr_ok && i_sr.addr == ASR_FLAGS)) begin
            st_nxt.ccr = calc_flags(i_alu);
        end
        if (i_trap_ret.valid) begin
            st_nxt.ccr = i_trap_ret.ccr;
        end
        st_nxt.alt.valid = i_alt.valid;
        st_nxt.alt.alternate_space_id = alt_id;
        st_nxt.alt.priv_action = i_alt.valid && alt_pa;
    end

    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st_r <= '0;
            st_r.y <= HIGH_WORD_RESET;
            st_r.ccr <= CCR_RESET;
            st_r.alternate_space_id <= SPACE_ID_RESET;
            st_r.npt <= NPT_RESET;
            st_r.cnt <= CNT_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ==========================================================
    // Outputs
    assign o_resp = st_r.resp;
    assign o_alt = st_r.alt;
    assign o_div_hi = st_r.y;
    assign o_ccr = st_r.ccr;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_sys_rst);

    logic ccr_quiet;
    assign ccr_quiet = !i_alu.valid && !i_trap_ret.valid &&
        !(i_sr.op == OP_WR_ASR && i_sr.addr == ASR_FLAGS);

    y_upper_zero_a: assert property (
        (i_sr.op == OP_RD_ASR && i_sr.addr == ASR_HIGH_WORD)
        |=> o_resp.valid && o_resp.data[63:32] == 32'h0
    ) else $error("high word upper half not zero");

    mul_hi_load_a: assert property (
        i_mul.valid |=> o_div_hi == $past(i_mul.product[63:32])
    ) else $error("product upper word not loaded");

    div_source_a: assert property (
        (i_sr.op == OP_WR_ASR && i_sr.addr == ASR_HIGH_WORD && !i_mul.valid)
        |=> o_div_hi == $past(i_sr.wdata[31:0])
    ) else $error("dividend upper word wrong");

    logic_flags_a: assert property (
        (i_alu.valid && i_alu.kind == ALU_LOGIC && !i_trap_ret.valid &&
         i_sr.op == OP_NONE)
        |=> o_ccr[7] == $past(i_alu.res[63]) &&
            o_ccr[3] == $past(i_alu.res[31]) &&
            o_ccr[6] == ($past(i_alu.res) == 64'h0) &&
            o_ccr[2] == ($past(i_alu.res[31:0]) == 32'h0)
    ) else $error("logic flags wrong");

    sub_carry_a: assert property (
        (i_alu.valid && i_alu.kind == ALU_SUB && !i_trap_ret.valid &&
         i_sr.op == OP_NONE)
        |=> o_ccr[0] == ($past(i_alu.a[31:0]) < $past(i_alu.b[31:0])) &&
            o_ccr[4] == ($past(i_alu.a) < $past(i_alu.b))
    ) else $error("subtract carry wrong");

    add_carry_a: assert property (
        (i_alu.valid && i_alu.kind == ALU_ADD && i_alu.a == 64'hFFFFFFFFFFFFFFFF
         && i_alu.b == 64'h1 && !i_trap_ret.valid && i_sr.op == OP_NONE)
        |=> o_ccr == 8'h55
    ) else $error("add carry wrong");

    flags_hold_a: assert property (
        ccr_quiet |=> $stable(o_ccr)
    ) else $error("flags changed without cause");

    trap_ret_a: assert property (
        i_trap_ret.valid |=> o_ccr == $past(i_trap_ret.ccr)
    ) else $error("flags not restored");

    cnt_step_a: assert property (
        !(i_sr.op == OP_WR_PR && i_mode == MODE_HYPER &&
          i_sr.addr == ASR_CYCLES)
        |=> st_r.cnt == ((($past(st_r.cnt)) + 63'h1) & CNT_MASK)
    ) else $error("counter did not step by one");

    cnt_write_a: assert property (
        (i_sr.op == OP_WR_PR && i_mode == MODE_HYPER &&
         i_sr.addr == ASR_CYCLES)
        |=> st_r.cnt == ($past(i_sr.wdata[62:0]) & CNT_MASK)
        ##1 st_r.cnt == ((($past(st_r.cnt)) + 63'h1) & CNT_MASK)
    ) else $error("counter write not honoured");

    user_block_a: assert property (
        (i_sr.op == OP_RD_ASR && i_sr.addr == ASR_CYCLES &&
         i_mode == MODE_USER)
        |=> o_resp.priv_action == $past(st_r.npt)
    ) else $error("user counter read check wrong");

    priv_write_a: assert property (
        (i_sr.op == OP_WR_PR && i_mode == MODE_PRIV)
        |=> o_resp.illegal && $stable(st_r.npt)
    ) else $error("privileged counter write allowed");

    alt_restrict_a: assert property (
        (i_alt.valid && !i_alt.imm_form && i_mode == MODE_USER &&
         i_alt.alternate_space_id[7] == 1'b0)
        |=> o_alt.priv_action
    ) else $error("restricted space id allowed");

    user_popc_a: assert property (
        ((i_sr.op == OP_RD_PR || i_sr.op == OP_WR_PR) &&
         i_mode == MODE_USER)
        |=> o_resp.valid && o_resp.priv_opcode && !o_resp.illegal
    ) else $error("user privileged access not refused");

    priv_read_a: assert property (
        (i_sr.op == OP_RD_ASR && i_sr.addr == ASR_CYCLES &&
         i_mode != MODE_USER)
        |=> !o_resp.priv_action && !o_resp.illegal &&
            o_resp.data == {$past(st_r.npt), $past(st_r.cnt) & CNT_MASK}
    ) else $error("privileged counter read refused");

    pr_read_a: assert property (
        (i_sr.op == OP_RD_PR && i_sr.addr == ASR_CYCLES &&
         i_mode != MODE_USER)
        |=> !o_resp.illegal && !o_resp.priv_opcode &&
            o_resp.data[63] == $past(st_r.npt)
    ) else $error("counter register read refused");

    user_open_a: assert property (
        (i_sr.op == OP_RD_ASR && i_sr.addr == ASR_CYCLES &&
         i_mode == MODE_USER && !st_r.npt)
        |=> !o_resp.priv_action && o_resp.data[63] == 1'b0
    ) else $error("open user counter read refused");

    flags_write_a: assert property (
        (i_sr.op == OP_WR_ASR && i_sr.addr == ASR_FLAGS &&
         !i_trap_ret.valid)
        |=> o_ccr == $past(i_sr.wdata[7:0])
    ) else $error("flags write not taken");

    space_write_a: assert property (
        (i_sr.op == OP_WR_ASR && i_sr.addr == ASR_SPACE_ID)
        |=> !o_resp.illegal && st_r.alternate_space_id == $past(i_sr.wdata[7:0])
    ) else $error("space id write not taken");

    hyper_alt_a: assert property (
        (i_alt.valid && i_mode == MODE_HYPER)
        |=> o_alt.valid && !o_alt.priv_action
    ) else $error("hyper alternate access refused");

    npt_write_a: assert property (
        (i_sr.op == OP_WR_PR && i_mode == MODE_HYPER &&
         i_sr.addr == ASR_CYCLES)
        |=> st_r.npt == $past(i_sr.wdata[63])
    ) else $error("block bit write not taken");

    cover_mul_c: cover property (i_mul.valid ##1 o_div_hi != 32'h0);
    cover_block_c: cover property (
        i_sr.op == OP_RD_ASR && i_mode == MODE_USER ##1 o_resp.priv_action);
    cover_trap_c: cover property (i_trap_ret.valid ##1 o_ccr != 8'h00);
    cover_tick_c: cover property (
        i_sr.op == OP_WR_PR && i_mode == MODE_HYPER ##1 !o_resp.illegal);
    cover_alt_c: cover property (i_alt.valid ##1 o_alt.priv_action);
endmodule // asr_regs

// ==== test/asr_alu_model.sv ====
`timescale 1ns/1ps
// ========
// Execution unit feeding results to the flag logic
module asr_alu_model
    import asr_pkg::*;
(
    // Operation
    input wire logic i_go,
    input wire asr_alu_t i_kind,
    input wire logic [63:0] i_a,
    input wire logic [63:0] i_b,
    // Flag request
    output asr_alu_req_t o_req
);
    // Logic kind modelled as and, enough to steer n and z
    always_comb begin
        o_req.valid = i_go;
        o_req.kind = i_kind;
        o_req.a = i_a;
        o_req.b = i_b;
        case (i_kind)
            ALU_ADD: o_req.res = i_a + i_b;
            ALU_SUB: o_req.res = i_a - i_b;
            default: o_req.res = i_a & i_b;
        endcase
    end
endmodule // asr_alu_model

// ==== test/asr_regs_bench.sv ====
`timescale 1ns/1ps
module asr_regs_bench;
    import asr_pkg::*;
    // ========
    // Stimulus and observation
    logic i_core_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    asr_mode_t i_mode = MODE_HYPER;
    asr_sr_req_t i_sr = '0;
    asr_mul_req_t i_mul = '0;
    asr_trap_ret_t i_trap_ret = '0;
    asr_alt_req_t i_alt = '0;
    logic alu_go = 1'b0;
    asr_alu_t alu_kind = ALU_ADD;
    logic [63:0] alu_a = 64'h0;
    logic [63:0] alu_b = 64'h0;
    asr_alu_req_t alu_req;
    asr_resp_t o_resp;
    asr_alt_resp_t o_alt;
    logic [31:0] o_div_hi;
    logic [7:0] o_ccr;
    logic [66:0] exp_q[$];
    logic [66:0] resp_got;
    logic [31:0] seed = 32'h63907889;
    logic [63:0] ra;
    logic [63:0] rb;
    logic [7:0] ids[6] = '{8'h00, 8'h2F, 8'h30, 8'h7F, 8'h80, 8'hFF};
    logic pa;
    int error_cnt = 0;
    int n_tests = 0;
    int cycles = 0;

    asr_alu_model partner (.i_go(alu_go), .i_kind(alu_kind), .i_a(alu_a),
        .i_b(alu_b), .o_req(alu_req));
    asr_regs uut (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
        .i_mode(i_mode), .i_sr(i_sr), .i_alu(alu_req), .i_mul(i_mul),
        .i_trap_ret(i_trap_ret), .i_alt(i_alt), .o_resp(o_resp),
        .o_alt(o_alt), .o_div_hi(o_div_hi), .o_ccr(o_ccr));

    // ========
    // Helpers
    task automatic finish_test;
        if (error_cnt == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic check(input logic [66:0] got, input logic [66:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [63:0] rnd();
        logic [63:0] v;
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        v[63:32] = seed;
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        v[31:0] = seed;
        return v;
    endfunction

    function automatic logic [7:0] flags(input asr_alu_t k,
        input logic [63:0] a, input logic [63:0] b);
        logic [64:0] s;
        logic [32:0] s32;
        logic [63:0] r;
        logic xv;
        logic iv;
        logic xc;
        logic ic;
        s = {1'b0, a} + {1'b0, b};
        s32 = {1'b0, a[31:0]} + {1'b0, b[31:0]};
        r = (k == ALU_ADD) ? s[63:0] : (k == ALU_SUB) ? a - b : a & b;
        xv = 1'b0;
        iv = 1'b0;
        xc = 1'b0;
        ic = 1'b0;
        if (k == ALU_ADD) begin
            xc = s[64];
            ic = s32[32];
            xv = (a[63] == b[63]) && (r[63] != a[63]);
            iv = (a[31] == b[31]) && (r[31] != a[31]);
        end else if (k == ALU_SUB) begin
            xc = a < b;
            ic = a[31:0] < b[31:0];
            xv = (a[63] != b[63]) && (r[63] != a[63]);
            iv = (a[31] != b[31]) && (r[31] != a[31]);
        end
        return {r[63], r == 64'h0, xv, xc, r[31], r[31:0] == 32'h0, iv, ic};
    endfunction

    // Request stays up; caller idles to drop it, so no double drive
    task automatic sr(input asr_mode_t m, input asr_op_t op,
        input logic [4:0] ad, input logic [63:0] wd, input logic [66:0] e);
        i_mode = m;
        i_sr = '{op, ad, wd};
        exp_q.push_back(e);
        @(negedge i_core_clk);
    endtask

    task automatic idle;
        i_sr.op = OP_NONE;
        @(negedge i_core_clk);
    endtask

    task automatic alu(input asr_alu_t k, input logic [63:0] a,
        input logic [63:0] b);
        alu_go = 1'b1;
        alu_kind = k;
        alu_a = a;
        alu_b = b;
        @(negedge i_core_clk);
        check({59'h0, o_ccr}, {59'h0, flags(k, a, b)});
    endtask

    // ========
    // Clock, watchdog, response monitor
    initial begin
        forever #2.5 i_core_clk = ~i_core_clk;
    end

    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            error_cnt++;
            finish_test();
        end
    end

    always @(negedge i_core_clk) begin
        if (o_resp.valid === 1'b1) begin
            resp_got = {o_resp.data, o_resp.illegal, o_resp.priv_opcode,
                o_resp.priv_action};
            if (exp_q.size() == 0)
                check(resp_got, ~resp_got);
            else
                check(resp_got, exp_q.pop_front());
        end
    end

    // ========
    // Scenarios
    initial begin
        repeat (12) @(negedge i_core_clk);
        i_sys_rst = 1'b0;
        sr(MODE_USER, OP_RD_ASR, ASR_CYCLES, 64'h0, 67'h1);
        sr(MODE_HYPER, OP_WR_ASR, ASR_HIGH_WORD, 64'hA5A5_A5A5_1234_5678,
            0);
        sr(MODE_USER, OP_RD_ASR, ASR_HIGH_WORD, 0,
            {64'h1234_5678, 3'h0});
        sr(MODE_PRIV, OP_WR_ASR, ASR_FLAGS, 64'hFFFF_FFFF_FFFF_FF3C,
            0);
        sr(MODE_USER, OP_RD_ASR, ASR_FLAGS, 0, {64'h3C, 3'h0});
        sr(MODE_USER, OP_WR_ASR, ASR_SPACE_ID, 64'h2B, 0);
        sr(MODE_USER, OP_RD_ASR, ASR_SPACE_ID, 0, {64'h2B, 3'h0});
        sr(MODE_HYPER, OP_WR_ASR, 5'h01, 64'h5, 67'h4);
        sr(MODE_HYPER, OP_WR_ASR, ASR_CYCLES, 64'h5, 67'h4);
        sr(MODE_USER, OP_RD_PR, ASR_CYCLES, 0, 67'h2);
        sr(MODE_USER, OP_WR_PR, ASR_CYCLES, 64'h5, 67'h2);
        sr(MODE_PRIV, OP_WR_PR, ASR_CYCLES, 64'h5, 67'h4);
        sr(MODE_HYPER, OP_WR_PR, ASR_CYCLES, 64'h100, 0);
        idle();
        sr(MODE_USER, OP_RD_ASR, ASR_CYCLES, 0, {64'h101, 3'h0});
        sr(MODE_PRIV, OP_RD_PR, ASR_CYCLES, 0, {64'h102, 3'h0});
        sr(MODE_HYPER, OP_RD_ASR, ASR_CYCLES, 0, {64'h103, 3'h0});
        sr(MODE_HYPER, OP_WR_PR, ASR_CYCLES, {64{1'b1}}, 0);
        idle();
        sr(MODE_USER, OP_RD_ASR, ASR_CYCLES, 0, 67'h1);
        sr(MODE_HYPER, OP_RD_PR, ASR_CYCLES, 0,
            {64'h8000_0000_0000_0001, 3'h0});
        idle();
        // Flags: corner cases first, then random operands
        alu(ALU_ADD, {64{1'b1}}, 64'h1);
        check({59'h0, o_ccr}, {59'h0, 8'h55});
        alu(ALU_ADD, 64'h7FFF_FFFF, 64'h1);
        alu(ALU_SUB, 64'h0, 64'h1);
        alu(ALU_SUB, 64'h8000_0000_0000_0000, 64'h1);
        alu(ALU_LOGIC, 64'hFFFF_FFFF, {64{1'b1}});
        for (int i = 0; i < 30; i++) begin
            ra = rnd();
            rb = rnd();
            alu(asr_alu_t'(i % 3), ra, rb);
        end
        alu_go = 1'b0;
        i_trap_ret = '{1'b1, 8'h96};
        @(negedge i_core_clk);
        i_trap_ret.valid = 1'b0;
        check({59'h0, o_ccr}, {59'h0, 8'h96});
        // Multiply upper word lands in the high-word register
        ra = rnd();
        i_mul = '{1'b1, ra};
        @(negedge i_core_clk);
        i_mul.valid = 1'b0;
        check({35'h0, o_div_hi}, {35'h0, ra[63:32]});
        sr(MODE_USER, OP_RD_ASR, ASR_HIGH_WORD, 0,
            {32'h0, ra[63:32], 3'h0});
        idle();
        // Alternate accesses across modes and range edges
        for (int m = 0; m < 3; m++) begin
            for (int j = 0; j < 6; j++) begin
                pa = (m == 0 && ids[j] <= 8'h7F) ||
                    (m == 1 && ids[j] >= 8'h30 && ids[j] <= 8'h7F);
                i_mode = asr_mode_t'(m);
                i_alt = '{1'b1, 1'b0, ids[j]};
                @(negedge i_core_clk);
                check({57'h0, o_alt}, {57'h0, 1'b1, ids[j], pa});
            end
        end
        i_mode = MODE_USER;
        i_alt = '{1'b1, 1'b1, 8'hEE};
        @(negedge i_core_clk);
        i_alt.valid = 1'b0;
        check({57'h0, o_alt}, {57'h0, 1'b1, 8'h2B, 1'b1});
        check({59'h0, o_ccr}, {59'h0, 8'h96});
        repeat (3) @(negedge i_core_clk);
        check(exp_q.size(), 0);
        finish_test();
    end
endmodule // asr_regs_bench
